// ===== dcb_diff_clock_buffer.v
// Function
// RULE1: Output runs only when its register bit is 1, pin low, power good, clock live.
// RULE2: Register enable bits are active high and reset to enabled.
// RULE3: A disabled output holds both legs low.
// RULE4: Enable pins are active low and asynchronous to every clock.
// RULE5: Pin falling restarts output glitch-free after 4 to 12 clock periods.
// RULE6: Pin rising gives at least four more clocks, stops within 12 periods.
// RULE7: Frequency strap 0 means 133.33 MHz, 1 means 100 MHz; output equals input.
// RULE8: Two tri-level address straps select one of nine bus addresses.
// RULE9: First power-good rise latches straps; afterwards pin acts as power-down.
// RULE10: Two consecutive low samples on clock rises force outputs low at next fall.
// RULE11: Power-down stops outputs first, then oscillator, then power saving; code stops outputs, oscillator and power saving in the same cycle.
// RULE12: Host drives power-down before stopping input clock or power.
// RULE13: Locked outputs appear under 1.8 ms after power good; code spends the full 1.8 ms in the lock window alone.
// RULE14: After power-down release outputs restart within 300 us; code spends the full 300 us in the restart window alone.
// RULE15: PLL strap L, M, H gives low bandwidth, bypass, high; readback 00, 01, 11.
// RULE16: Override bit set makes bits 2:1 replace strap PLL mode.
// RULE17: Readback bits 7:6 always show the strap-latched mode.
// RULE18: Software does a warm reset after changing override mode bits.
// RULE19: Management interface runs at 100 kbps, 400 kbps optional.
// RULE20: Never hold management clock or data low over 10 ms.
// RULE21: In power-down management inputs are high impedance; registers retained.
// RULE22: General call address need not be answered.
// RULE23: Enable and power-down pins pass two flip-flops before use.
`timescale 1ns/1ps
`default_nettype none
`include "dcb_regs.vh"
module dcb_diff_clock_buffer #(
  parameter NUM_OUT    = 6,
  parameter LOCK_CYC   = `DCB_LOCK_US * `DCB_CLK_MHZ - 1,
  parameter RESTART_CYC = `DCB_RESTART_US * `DCB_CLK_MHZ - 1
) (
  // System
  input  wire               clk,
  input  wire               sys_rst,
  // AXI4-Lite write address
  input  wire [3:0]         s_axi_awaddr,
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]         s_axi_bresp,
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]         s_axi_araddr,
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  // Input reference clock and pins
  input  wire               refClkIn,
  input  wire [NUM_OUT-1:0] outEnableN,
  input  wire               power_good,
  input  wire               freq_select_strap,
  input  wire [1:0]         addr_strap_low,
  input  wire [1:0]         addr_strap_high,
  input  wire [1:0]         pll_bw_strap,
  // Differential outputs
  output reg  [NUM_OUT-1:0] diffClockOutP,
  output reg  [NUM_OUT-1:0] diffClockOutN,
  // Device state
  output reg                oscOn,
  output reg                powerSave,
  output reg                mgmtHiZ,
  output reg  [7:0]         busAddr,
  output reg                freqIs100,
  output wire [1:0]         pllMode,
  output wire               pllBypass
);

  localparam PS_OFF   = 2'h0;
  localparam PS_LOCK  = 2'h1;
  localparam PS_RUN   = 2'h2;
  localparam PS_STOP  = 2'h3;

  // Synchronisers
  reg  [2:0]         refSync_r;
  reg  [NUM_OUT-1:0] oeMeta_r;
  reg  [NUM_OUT-1:0] oeSync_r;
  reg                pgMeta_r;
  reg                pgSync_r;
  reg  [6:0]         strapMeta_r;
  reg  [6:0]         strapSync_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      refSync_r <= 3'h0;
      oeMeta_r  <= {NUM_OUT{1'b1}};
      oeSync_r  <= {NUM_OUT{1'b1}};
      pgMeta_r  <= 1'b0;
      pgSync_r  <= 1'b0;
      strapMeta_r <= 7'h00;
      strapSync_r <= 7'h00;
    end else begin
      refSync_r <= {refSync_r[1:0], refClkIn};
      oeMeta_r  <= outEnableN; // [RULE4]
      oeSync_r  <= oeMeta_r; // [RULE23]
      pgMeta_r  <= power_good;
      pgSync_r  <= pgMeta_r; // [RULE23]
      strapMeta_r <= {freq_select_strap, addr_strap_high, addr_strap_low, pll_bw_strap};
      strapSync_r <= strapMeta_r;
    end
  end

  wire refLevel = refSync_r[1];
  wire refRise  = refSync_r[1] & ~refSync_r[2];
  wire refFall  = ~refSync_r[1] & refSync_r[2];
  wire       freqStrap = strapSync_r[6];
  wire [1:0] addrHigh  = strapSync_r[5:4];
  wire [1:0] addrLow   = strapSync_r[3:2];
  wire [1:0] pllStrap  = strapSync_r[1:0];

  // Registers
  reg  [7:0]         ctrl_r;
  reg  [NUM_OUT-1:0] regEn_r;
  reg                strapDone_r;
  reg  [1:0]         strapMode_r;

  // Strap capture on first power-good rise
  reg                pgPrev_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      pgPrev_r    <= 1'b0;
      strapDone_r <= 1'b0;
      strapMode_r <= `DCB_PLL_LBW;
      freqIs100   <= 1'b0;
      busAddr     <= 8'h00;
    end else begin
      pgPrev_r <= pgSync_r;
      if (pgSync_r && !pgPrev_r && !strapDone_r) begin // [RULE9]
        strapDone_r <= 1'b1;
        freqIs100   <= freqStrap; // [RULE7]
        case (pllStrap) // [RULE15]
          `DCB_TRI_L: strapMode_r <= `DCB_PLL_LBW;
          `DCB_TRI_M: strapMode_r <= `DCB_PLL_BYP;
          default:    strapMode_r <= `DCB_PLL_HBW;
        endcase
        // None of the nine is the general call address [RULE22]
        case ({addrHigh, addrLow}) // [RULE8]
          {`DCB_TRI_L, `DCB_TRI_L}: busAddr <= 8'hD8;
          {`DCB_TRI_L, `DCB_TRI_M}: busAddr <= 8'hDA;
          {`DCB_TRI_L, `DCB_TRI_H}: busAddr <= 8'hDE;
          {`DCB_TRI_M, `DCB_TRI_L}: busAddr <= 8'hC2;
          {`DCB_TRI_M, `DCB_TRI_M}: busAddr <= 8'hC4;
          {`DCB_TRI_M, `DCB_TRI_H}: busAddr <= 8'hC6;
          {`DCB_TRI_H, `DCB_TRI_L}: busAddr <= 8'hCA;
          {`DCB_TRI_H, `DCB_TRI_M}: busAddr <= 8'hCC;
          default:                  busAddr <= 8'hCE;
        endcase
      end
    end
  end

  // PLL mode: override bits win when enabled
  reg  [1:0]         pllMode_r;
  reg                pllBypass_r;
  wire [1:0]         pllMode_nxt = ctrl_r[`DCB_OVRD_BIT] ? // [RULE16]
                                   {ctrl_r[`DCB_MODE_HI_BIT], ctrl_r[`DCB_MODE_LO_BIT]} : strapMode_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      pllMode_r   <= `DCB_PLL_LBW;
      pllBypass_r <= 1'b0;
    end else begin
      pllMode_r   <= pllMode_nxt;
      pllBypass_r <= (pllMode_nxt == `DCB_PLL_BYP); // [RULE15]
    end
  end

  assign pllMode   = pllMode_r;
  assign pllBypass = pllBypass_r;

  // Power sequencing
  reg  [1:0]  pState_r;
  reg  [18:0] pCnt_r;
  reg  [1:0]  pdLowCnt_r;
  reg         pdForce_r;
  reg         warm_r;

  always @(posedge clk) begin
    if (sys_rst) begin
      pState_r   <= PS_OFF;
      pCnt_r     <= 19'h0;
      pdLowCnt_r <= 2'h0;
      pdForce_r  <= 1'b1;
      warm_r     <= 1'b0;
      oscOn      <= 1'b0;
      powerSave  <= 1'b1;
      mgmtHiZ    <= 1'b0;
    end else begin
      case (pState_r)
        PS_OFF: begin
          if (pgSync_r) begin
            oscOn     <= 1'b1;
            powerSave <= 1'b0;
            mgmtHiZ   <= 1'b0;
            pCnt_r    <= warm_r ? RESTART_CYC[18:0] : LOCK_CYC[18:0];
            pState_r  <= PS_LOCK;
          end
        end
        PS_LOCK: begin
          // Lock window lasts 1.8 ms, restart window lasts 300 us
          if (!pgSync_r) begin
            pState_r <= PS_STOP;
          end else if (pCnt_r == 19'h0) begin // [RULE13] [RULE14]
            pdForce_r  <= 1'b0;
            pdLowCnt_r <= 2'h0;
            warm_r     <= 1'b1;
            pState_r   <= PS_RUN;
          end else begin
            pCnt_r <= pCnt_r - 19'h1;
          end
        end
        PS_RUN: begin
          if (refRise) begin
            if (pgSync_r)
              pdLowCnt_r <= 2'h0;
            else if (pdLowCnt_r != 2'h2)
              pdLowCnt_r <= pdLowCnt_r + 2'h1;
          end
          // Two low samples, then park at the next fall
          if (refFall && pdLowCnt_r == 2'h2) begin // [RULE10]
            pdForce_r <= 1'b1;
            pState_r  <= PS_STOP;
          end
        end
        PS_STOP: begin
          // Outputs coming from run park on the same edge that stops the oscillator
          pdForce_r <= 1'b1; // [RULE11]
          oscOn     <= 1'b0;
          powerSave <= 1'b1;
          mgmtHiZ   <= 1'b1; // [RULE21]
          pState_r  <= PS_OFF;
        end
        default: pState_r <= PS_OFF;
      endcase
    end
  end

  // Per-output glitch-free gating
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g = g + 1) begin : gOut
      reg       run_r;
      reg [3:0] lat_r;
      wire      want = regEn_r[g] & ~oeSync_r[g]; // [RULE1]

      always @(posedge clk) begin
        if (sys_rst) begin
          run_r <= 1'b0;
          lat_r <= 4'h0;
        end else if (pdForce_r) begin
          run_r <= 1'b0;
          lat_r <= 4'h0;
        end else if (want == run_r) begin
          lat_r <= 4'h0;
        end else if (refRise && lat_r != `DCB_OE_CLOCKS) begin
          lat_r <= lat_r + 4'h1; // [RULE6]
        end else if (refFall && lat_r == `DCB_OE_CLOCKS) begin
          run_r <= want; // [RULE5]
          lat_r <= 4'h0;
        end
      end

      always @(posedge clk) begin
        if (sys_rst) begin
          diffClockOutP[g] <= 1'b0;
          diffClockOutN[g] <= 1'b0;
        end else if (run_r && !pdForce_r) begin
          diffClockOutP[g] <= refLevel; // [RULE7]
          diffClockOutN[g] <= ~refLevel;
        end else begin
          diffClockOutP[g] <= 1'b0; // [RULE3]
          diffClockOutN[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Serial engine sits outside; nothing here holds its lines low [RULE19] [RULE20]
  // AXI4-Lite write path
  wire wrGo = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wrGo;
  assign s_axi_wready  = wrGo;
  wire [7:0] wb = s_axi_wdata[7:0];
  wire       wrLane = s_axi_wstrb[0];

  always @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r       <= `DCB_CTRL_RST;
      regEn_r      <= `DCB_OE_RST; // [RULE2]
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DCB_RESP_OK;
    end else begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wrGo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `DCB_RESP_OK;
        case (s_axi_awaddr)
          `DCB_CTRL_ADDR: begin
            if (wrLane) // [RULE16]
              ctrl_r[3:1] <= wb[3:1];
          end
          `DCB_OE_LO_ADDR: begin
            if (wrLane) begin
              regEn_r[0] <= wb[`DCB_OE0_BIT];
              regEn_r[1] <= wb[`DCB_OE1_BIT];
              regEn_r[2] <= wb[`DCB_OE2_BIT];
              regEn_r[3] <= wb[`DCB_OE3_BIT];
            end
          end
          `DCB_OE_HI_ADDR: begin
            if (wrLane) begin
              regEn_r[4] <= wb[`DCB_OE4_BIT];
              regEn_r[5] <= wb[`DCB_OE5_BIT];
            end
          end
          `DCB_STAT_ADDR: s_axi_bresp <= `DCB_RESP_OK;
          default:        s_axi_bresp <= `DCB_RESP_ERR;
        endcase
      end
    end
  end

  // AXI4-Lite read path
  assign s_axi_arready = ~s_axi_rvalid;
  reg [31:0] rdNxt;
  reg        rdErr;

  always @* begin
    rdNxt = 32'h0;
    rdErr = 1'b0;
    case (s_axi_araddr)
      `DCB_CTRL_ADDR: begin
        rdNxt[`DCB_FREQ_BIT] = freqIs100;
        rdNxt[3:1] = ctrl_r[3:1];
        rdNxt[`DCB_RB_HI_BIT] = strapMode_r[1]; // [RULE17]
        rdNxt[`DCB_RB_LO_BIT] = strapMode_r[0]; // [RULE17]
      end
      `DCB_OE_LO_ADDR: begin
        rdNxt[`DCB_OE0_BIT] = regEn_r[0];
        rdNxt[`DCB_OE1_BIT] = regEn_r[1];
        rdNxt[`DCB_OE2_BIT] = regEn_r[2];
        rdNxt[`DCB_OE3_BIT] = regEn_r[3];
      end
      `DCB_OE_HI_ADDR: begin
        rdNxt[`DCB_OE4_BIT] = regEn_r[4];
        rdNxt[`DCB_OE5_BIT] = regEn_r[5];
      end
      `DCB_STAT_ADDR: begin
        rdNxt[7:0] = busAddr;
        rdNxt[8]   = strapDone_r;
        rdNxt[9]   = ~pdForce_r;
        rdNxt[10]  = oscOn;
        rdNxt[11]  = powerSave;
        rdNxt[13:12] = pllMode;
      end
      default: rdErr = 1'b1;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `DCB_RESP_OK;
    end else begin
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdNxt;
        s_axi_rresp  <= rdErr ? `DCB_RESP_ERR : `DCB_RESP_OK;
      end
    end
  end

endmodule
`default_nettype wire

// ===== dcb_regs.vh
`ifndef DCB_REGS_VH
`define DCB_REGS_VH
// Register byte addresses
`define DCB_CTRL_ADDR    4'h0
`define DCB_OE_LO_ADDR   4'h4
`define DCB_OE_HI_ADDR   4'h8
`define DCB_STAT_ADDR    4'hC
// Control word fields
`define DCB_FREQ_BIT     0
`define DCB_MODE_LO_BIT  1
`define DCB_MODE_HI_BIT  2
`define DCB_OVRD_BIT     3
`define DCB_RB_LO_BIT    6
`define DCB_RB_HI_BIT    7
`define DCB_CTRL_RST     8'h06
// Enable word bit positions, outputs 0..5
`define DCB_OE0_BIT      1
`define DCB_OE1_BIT      2
`define DCB_OE2_BIT      5
`define DCB_OE3_BIT      6
`define DCB_OE4_BIT      0
`define DCB_OE5_BIT      2
`define DCB_OE_RST       6'h3F
// Tri-level strap codes
`define DCB_TRI_L        2'h0
`define DCB_TRI_M        2'h1
`define DCB_TRI_H        2'h2
// PLL mode codes
`define DCB_PLL_LBW      2'h0
`define DCB_PLL_BYP      2'h1
`define DCB_PLL_HBW      2'h3
// Timing
`define DCB_CLK_MHZ      200
`define DCB_LOCK_US      1800
`define DCB_RESTART_US   300
`define DCB_OE_CLOCKS    4
`define DCB_RESP_OK      2'h0
`define DCB_RESP_ERR     2'h2
`endif

// ===== dcb_diff_clock_buffer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dcb_diff_clock_buffer_assertions #(parameter NUM_OUT = 6) (
  // Clock and reset
  input wire logic               clk,
  input wire logic               sys_rst,
  // Pins and state
  input wire logic [NUM_OUT-1:0] outEnableN,
  input wire logic               power_good,
  input wire logic [NUM_OUT-1:0] diffClockOutP,
  input wire logic [NUM_OUT-1:0] diffClockOutN,
  input wire logic               oscOn,
  input wire logic               powerSave,
  input wire logic               mgmtHiZ,
  input wire logic [7:0]         busAddr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic [NUM_OUT-1:0] live = diffClockOutP | diffClockOutN;
  property p_legs; (diffClockOutP & diffClockOutN) == '0; endproperty
  a_legs: assert property (p_legs) else $error("legs both high");
  property p_quiet; powerSave |-> live == '0; endproperty
  a_quiet: assert property (p_quiet) else $error("clock in power save");
  property p_stop; $fell(oscOn) |-> live == '0 && powerSave; endproperty
  a_stop: assert property (p_stop) else $error("osc off before clocks");
  property p_down; $fell(power_good) && oscOn |-> ##[1:90] (power_good || live == '0); endproperty
  a_down: assert property (p_down) else $error("power down late");
  property p_hold; $fell(power_good) && live != '0 |-> (live != '0) [*8]; endproperty
  a_hold: assert property (p_hold) else $error("power down early");
  property p_late; $rose(outEnableN[0]) && live[0] |-> ##48 live[0] ##[1:150] !live[0]; endproperty
  a_late: assert property (p_late) else $error("pin stop timing");
  property p_latch; busAddr != 8'h00 |=> $stable(busAddr); endproperty
  a_latch: assert property (p_latch) else $error("address relatched");
  property p_addr;
    busAddr != 8'h00 |-> busAddr inside {8'hD8, 8'hDA, 8'hDE, 8'hC2, 8'hC4, 8'hC6, 8'hCA, 8'hCC, 8'hCE};
  endproperty
  a_addr: assert property (p_addr) else $error("bad address");
  property p_hiz; $rose(mgmtHiZ) |-> powerSave && !oscOn; endproperty
  a_hiz: assert property (p_hiz) else $error("pins floated early");
  c_down: cover property ($fell(oscOn));
  c_late: cover property ($rose(outEnableN[0]) && live[0]);
  c_addr: cover property (busAddr == 8'hCE);
endmodule
`default_nettype wire

// ===== dcb_power_seq_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcb_power_seq_model (
  // Request
  input  wire logic pwrReq,
  // Board side
  output var logic  refClkIn,
  output var logic  power_good
);
  logic clkOn = 1'b0;
  initial begin
    refClkIn = 1'b0;
    power_good = 1'b0;
    #11;
    forever #40 refClkIn = clkOn & ~refClkIn;
  end
  always @(posedge pwrReq) begin
    clkOn = 1'b1;
    #400 power_good = pwrReq;
  end
  always @(negedge pwrReq) begin
    power_good = 1'b0;
    #2000 clkOn = pwrReq;
  end
endmodule
`default_nettype wire

// ===== dcb_diff_clock_buffer_test.sv
`timescale 1ns/1ps
`default_nettype none
module dcb_diff_clock_buffer_test;
  logic        clk = 1'b0, sys_rst = 1'b1, pwrReq = 1'b0, freq_select_strap = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_wstrb = 4'hF, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0]  addr_strap_low = 2'h0, addr_strap_high = 2'h0, pll_bw_strap = 2'h0;
  logic [5:0]  outEnableN = 6'h00, seen;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, pllMode;
  wire  [31:0] s_axi_rdata;
  wire         refClkIn, power_good, oscOn, powerSave, mgmtHiZ, freqIs100, pllBypass;
  wire  [5:0]  diffClockOutP, diffClockOutN;
  wire  [7:0]  busAddr;
  int          nErrors = 0, cmpCount = 0, cycles = 0;
  int          oeBit[6] = '{1, 2, 5, 6, 0, 2};
  logic [7:0]  addrTab[9] = '{8'hD8, 8'hDA, 8'hDE, 8'hC2, 8'hC4, 8'hC6, 8'hCA, 8'hCC, 8'hCE};
  logic [1:0]  modeTab[3] = '{2'h0, 2'h1, 2'h3};
  dcb_diff_clock_buffer #(.LOCK_CYC(20), .RESTART_CYC(20)) dut (
    .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .refClkIn, .outEnableN, .power_good,
    .freq_select_strap, .addr_strap_low, .addr_strap_high, .pll_bw_strap, .diffClockOutP, .diffClockOutN,
    .oscOn, .powerSave, .mgmtHiZ, .busAddr, .freqIs100, .pllMode, .pllBypass);
  dcb_power_seq_model psm (.pwrReq, .refClkIn, .power_good);
  initial forever #2.5 clk = ~clk;
  task automatic giveVerdict;
    if (nErrors == 0 && cmpCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      nErrors++;
      giveVerdict;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axiWrite(input logic [3:0] a, input logic [31:0] d);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (!awDone && s_axi_awready) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wDone && s_axi_wready) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), 32'h0);
    @(posedge clk);
  endtask
  task automatic axiRead(input logic [3:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    check(32'(s_axi_rresp), 32'h0);
    @(posedge clk);
  endtask
  // Collects any leg activity over two and a half reference periods
  task automatic watchAll(input logic [5:0] exp);
    seen = 6'h00;
    repeat (40) begin
      @(posedge clk);
      seen = seen | diffClockOutP | diffClockOutN;
    end
    check(32'(seen), 32'(exp));
  endtask
  task automatic powerUp(input logic on);
    pwrReq <= on;
    repeat (500) @(posedge clk);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    axiRead(4'h4, rd);
    check(rd, 32'h66);
    axiRead(4'h8, rd);
    check(rd, 32'h05);
    axiRead(4'h0, rd);
    check(rd & 32'hE, 32'h6);
    for (int i = 0; i < 9; i++) begin
      sys_rst <= 1'b1;
      addr_strap_high <= 2'(i / 3);
      addr_strap_low <= 2'(i % 3);
      pll_bw_strap <= 2'(i % 3);
      freq_select_strap <= i[0];
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      powerUp(1'b1);
      check(32'(busAddr), 32'(addrTab[i]));
      check(32'(freqIs100), 32'(i[0]));
      axiRead(4'h0, rd);
      check(rd & 32'hC1, 32'({modeTab[i % 3], 5'h0, i[0]}));
      addr_strap_high <= 2'((i + 1) % 3);
      addr_strap_low <= 2'((i + 1) % 3);
      freq_select_strap <= ~i[0];
      repeat (8) @(posedge clk);
      check(32'(busAddr), 32'(addrTab[i]));
      check(32'(freqIs100), 32'(i[0]));
      if (i < 8) powerUp(1'b0);
    end
    watchAll(6'h3F);
    outEnableN <= 6'h01;
    watchAll(6'h3F);
    repeat (200) @(posedge clk);
    watchAll(6'h3E);
    outEnableN <= 6'h00;
    watchAll(6'h3E);
    repeat (200) @(posedge clk);
    watchAll(6'h3F);
    for (int b = 0; b < 6; b++) begin
      axiWrite(4'h4, 32'h66 & ~((b < 4) ? 32'h1 << oeBit[b] : 32'h0));
      axiWrite(4'h8, 32'h05 & ~((b > 3) ? 32'h1 << oeBit[b] : 32'h0));
      repeat (200) @(posedge clk);
      watchAll(6'h3F & ~(6'h01 << b));
    end
    axiWrite(4'h8, 32'h05);
    for (int m = 0; m < 3; m++) begin
      axiWrite(4'h0, 32'h8 | (32'(modeTab[m]) << 1));
      check(32'(pllMode), 32'(modeTab[m]));
      check(32'(pllBypass), 32'(m == 1));
      axiRead(4'h0, rd);
      check(rd & 32'hC0, 32'hC0);
    end
    axiWrite(4'h0, 32'h0);
    check(32'(pllMode), 32'h3);
    powerUp(1'b0);
    watchAll(6'h00);
    check(32'({oscOn, powerSave, mgmtHiZ}), 32'h3);
    axiRead(4'h4, rd);
    check(rd, 32'h66);
    powerUp(1'b1);
    watchAll(6'h3F);
    check(32'(busAddr), 32'hCE);
    axiRead(4'hC, rd);
    check(rd, 32'h37CE);
    giveVerdict;
  end
endmodule
bind dcb_diff_clock_buffer dcb_diff_clock_buffer_assertions #(.NUM_OUT(NUM_OUT)) sva (
  .clk, .sys_rst, .outEnableN, .power_good, .diffClockOutP, .diffClockOutN, .oscOn, .powerSave, .mgmtHiZ,
  .busAddr);
`default_nettype wire
